// ==== epi_pkg.sv ====
package epi_pkg;

    // dedicated input sense encodings
    localparam logic [1:0] EPI_SENSE_LOW  = 2'h0;
    localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
    localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

    localparam int EPI_GROUP_W  = 8;
    localparam int EPI_N_GROUPS = 3;
    localparam int EPI_N_CHANGE = EPI_GROUP_W * EPI_N_GROUPS;

    // group 1 has only seven pins, the top bit is absent
    localparam logic [7:0] EPI_GROUP0_VALID = 8'hFF;
    localparam logic [7:0] EPI_GROUP1_VALID = 8'h7F;
    localparam logic [7:0] EPI_GROUP2_VALID = 8'hFF;

    localparam int EPI_CLK_MHZ = 100;

    // start-up base time, doubled per step of the start-up fuses, and time per clock-select step
    localparam int EPI_STARTUP_UNIT_NS  = 1000;
    localparam int EPI_STARTUP_CLOCK_SELECT_FUSES_NS = 160;
    localparam int EPI_CNT_W            = 12;
    localparam logic [EPI_CNT_W-1:0] EPI_STARTUP_UNIT_CYC =
        EPI_CNT_W'((EPI_STARTUP_UNIT_NS * EPI_CLK_MHZ + 999) / 1000);
    localparam logic [EPI_CNT_W-1:0] EPI_STARTUP_CLOCK_SELECT_FUSES_CYC =
        EPI_CNT_W'((EPI_STARTUP_CLOCK_SELECT_FUSES_NS * EPI_CLK_MHZ + 999) / 1000);
    localparam logic [EPI_CNT_W-1:0] EPI_CNT_ZERO = 12'h000;
    localparam logic [EPI_CNT_W-1:0] EPI_CNT_ONE  = 12'h001;

    typedef enum logic [2:0] {
        EPI_ST_AWAKE   = 3'b001,
        EPI_ST_SLEEP   = 3'b010,
        EPI_ST_STARTUP = 3'b100
    } epi_state_t;

endpackage

// ==== epi_sense_detect.sv ====
`timescale 1ns/1ps
module epi_sense_detect
    import epi_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       pinLevel,
    input  wire logic [1:0] sense,
    input  wire logic       enable,
    input  wire logic       ioClkRun,
    input  wire logic       flagClear,
    output logic            edgeFlag,
    output logic            lowLevel
);

    logic prev_q;
    logic prev_d;
    logic flag_q;
    logic flag_d;
    logic edgeHit;

    always_comb begin
        // the sample only advances while the i/o clock runs
        prev_d  = ioClkRun ? pinLevel : prev_q;                   // see RQ14
        edgeHit = 1'b0;
        if (enable && ioClkRun) begin                              // see RQ9
            unique case (sense)
                EPI_SENSE_RISE: edgeHit = pinLevel & ~prev_q;      // see RQ14
                EPI_SENSE_FALL: edgeHit = ~pinLevel & prev_q;      // see RQ14
                default:        edgeHit = 1'b0;
            endcase
        end
        // a new edge wins over a clear in the same cycle
        flag_d = edgeHit | (flag_q & ~flagClear);                  // see RQ7
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b1;
            flag_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            flag_q <= flag_d;
        end
    end

    assign edgeFlag = flag_q;
    // low level needs no clock
    assign lowLevel = enable && (sense == EPI_SENSE_LOW)
                   && !pinLevel;                                   // see RQ11

    a_edge_rise: assert property (@(posedge clock) // see RQ7
        disable iff (!rstn)
        enable && ioClkRun && sense == EPI_SENSE_RISE && pinLevel && !prev_q
        |=> edgeFlag)
        else $error("rising edge not flagged");

    a_edge_gated: assert property (@(posedge clock) // see RQ9
        disable iff (!rstn)
        !ioClkRun && !edgeFlag |=> !edgeFlag)
        else $error("edge flagged while i/o clock stopped");

endmodule

// ==== epi_ext_interrupts.sv ====
`timescale 1ns/1ps
// Summary of operation
// RQ1: pins driven as outputs still raise interrupts
// RQ2: any enabled toggle on pins 23..16 requests group2
// RQ3: any enabled toggle on pins 14..8 requests group1
// RQ4: any enabled toggle on pins 7..0 requests group0
// RQ5: per-group masks select contributing pins
// RQ6: pin-change detection works without the i/o clock
// RQ7: dedicated inputs sense falling, rising or low level
// RQ8: low level requests continuously while pin low
// RQ9: edge sensing needs the running i/o clock
// RQ10: i/o clock stops in all deep sleep modes
// RQ11: low level detection is asynchronous, wakes deep sleep
// RQ12: level gone before start-up end: wake, no interrupt
// RQ13: start-up delay comes from start-up and clock fuses
// RQ14: edges found from successive i/o clock samples
module epi_ext_interrupts
    import epi_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    extIrqPinA,
    input  wire logic                    extIrqPinAOut,
    input  wire logic                    extIrqPinAOe,
    input  wire logic                    extIrqPinB,
    input  wire logic                    extIrqPinBOut,
    input  wire logic                    extIrqPinBOe,
    input  wire logic [3:0]              extIrqSenseCtrl,
    input  wire logic [1:0]              extIrqEnable,
    input  wire logic [1:0]              extIrqAck,
    input  wire logic [EPI_N_CHANGE-1:0] changePins,
    input  wire logic [EPI_N_CHANGE-1:0] changePinsOut,
    input  wire logic [EPI_N_CHANGE-1:0] changePinsOe,
    input  wire logic [7:0]              changeMaskGroup0,
    input  wire logic [7:0]              changeMaskGroup1,
    input  wire logic [7:0]              changeMaskGroup2,
    input  wire logic [2:0]              changeEnable,
    input  wire logic [2:0]              changeAck,
    input  wire logic                    sleepEnter,
    input  wire logic                    sleepIdleMode,
    input  wire logic [1:0]              startupTimeFuses,
    input  wire logic [3:0]              clockSelectFuses,
    output logic                         extIrqReqA,
    output logic                         extIrqReqB,
    output logic                         changeReqGroup0,
    output logic                         changeReqGroup1,
    output logic                         changeReqGroup2,
    output logic                         ioClockRun,
    output logic                         wakeUp
);

    // pin synchronisers
    logic [EPI_N_CHANGE-1:0] chgMeta_q;
    logic [EPI_N_CHANGE-1:0] chgSync_q;
    logic [1:0]              extMeta_q;
    logic [1:0]              extSync_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chgMeta_q <= '0;
            chgSync_q <= '0;
            extMeta_q <= 2'h3;
            extSync_q <= 2'h3;
        end else begin
            chgMeta_q <= changePins;
            chgSync_q <= chgMeta_q;
            extMeta_q <= {extIrqPinB, extIrqPinA};
            extSync_q <= extMeta_q;
        end
    end

    // a pin that the device drives is seen at its driven value
    logic [EPI_N_CHANGE-1:0] chgLevel;
    logic                    levelA;
    logic                    levelB;

    assign chgLevel = (changePinsOe & changePinsOut)
                    | (~changePinsOe & chgSync_q);                 // see RQ1
    assign levelA   = extIrqPinAOe ? extIrqPinAOut : extSync_q[0]; // see RQ1
    assign levelB   = extIrqPinBOe ? extIrqPinBOut : extSync_q[1]; // see RQ1

    // pin-change groups
    logic [EPI_N_CHANGE-1:0] chgPrev_q;
    logic [EPI_N_CHANGE-1:0] chgPrev_d;
    logic [EPI_N_CHANGE-1:0] chgToggle;
    logic [EPI_N_CHANGE-1:0] allMask;
    logic [2:0]              grpHit;
    logic [2:0]              grpFlag_q;
    logic [2:0]              grpFlag_d;

    assign allMask = {changeMaskGroup2 & EPI_GROUP2_VALID,
                      changeMaskGroup1 & EPI_GROUP1_VALID,
                      changeMaskGroup0 & EPI_GROUP0_VALID};        // see RQ5

    always_comb begin
        // sampled on every clock, independent of the i/o clock
        chgPrev_d = chgLevel;                                      // see RQ6
        chgToggle = chgLevel ^ chgPrev_q;
        for (int g = 0; g < EPI_N_GROUPS; g++) begin
            grpHit[g] = changeEnable[g]
                && |(chgToggle[g*EPI_GROUP_W +: EPI_GROUP_W]
                   & allMask[g*EPI_GROUP_W +: EPI_GROUP_W]);       // see RQ5
            // set wins over clear
            grpFlag_d[g] = grpHit[g] | (grpFlag_q[g] & ~changeAck[g]);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chgPrev_q <= '0;
            grpFlag_q <= 3'h0;
        end else begin
            chgPrev_q <= chgPrev_d;
            grpFlag_q <= grpFlag_d;
        end
    end

    assign changeReqGroup0 = grpFlag_q[0];                         // see RQ4
    assign changeReqGroup1 = grpFlag_q[1];                         // see RQ3
    assign changeReqGroup2 = grpFlag_q[2];                         // see RQ2

    // sleep and start-up sequencing
    epi_state_t             state_q;
    epi_state_t             state_d;
    logic [EPI_CNT_W-1:0]   cnt_q;
    logic [EPI_CNT_W-1:0]   cnt_d;
    logic                   wake_q;
    logic                   wake_d;
    logic [EPI_CNT_W-1:0]   startLoad;
    logic                   lowA;
    logic                   lowB;
    logic                   edgeA;
    logic                   edgeB;
    logic                   wakeSrc;
    logic                   ioClkRun;

    assign ioClkRun = (state_q == EPI_ST_AWAKE)
                   || (state_q == EPI_ST_SLEEP && sleepIdleMode);  // see RQ10

    assign startLoad = (EPI_STARTUP_UNIT_CYC << startupTimeFuses)
                     + ({8'h00, clockSelectFuses}
                        * EPI_STARTUP_CLOCK_SELECT_FUSES_CYC);                  // see RQ13

    // edge flags only count as wake sources while the i/o clock runs
    assign wakeSrc = lowA || lowB || (|grpFlag_q)
                  || (ioClkRun && (edgeA || edgeB));               // see RQ11

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wake_d  = 1'b0;
        unique case (state_q)
            EPI_ST_AWAKE: begin
                if (sleepEnter) begin
                    state_d = EPI_ST_SLEEP;
                end
            end
            EPI_ST_SLEEP: begin
                if (wakeSrc) begin
                    wake_d = 1'b1;
                    if (sleepIdleMode) begin
                        state_d = EPI_ST_AWAKE;
                    end else begin
                        state_d = EPI_ST_STARTUP;                  // see RQ13
                        cnt_d   = (startLoad == EPI_CNT_ZERO)
                                ? EPI_CNT_ONE : startLoad;
                    end
                end
            end
            EPI_ST_STARTUP: begin
                cnt_d = cnt_q - EPI_CNT_ONE;
                if (cnt_q == EPI_CNT_ONE) begin
                    state_d = EPI_ST_AWAKE;
                end
            end
            default: begin
                state_d = EPI_ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= EPI_ST_AWAKE;
            cnt_q   <= EPI_CNT_ZERO;
            wake_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wake_q  <= wake_d;
        end
    end

    assign ioClockRun = ioClkRun;
    assign wakeUp     = wake_q;

    // dedicated inputs
    epi_sense_detect u_sense_a (
        .clock     (clock),
        .rstn      (rstn),
        .pinLevel  (levelA),
        .sense     (extIrqSenseCtrl[1:0]),
        .enable    (extIrqEnable[0]),
        .ioClkRun  (ioClkRun),
        .flagClear (extIrqAck[0]),
        .edgeFlag  (edgeA),
        .lowLevel  (lowA)
    );

    epi_sense_detect u_sense_b (
        .clock     (clock),
        .rstn      (rstn),
        .pinLevel  (levelB),
        .sense     (extIrqSenseCtrl[3:2]),
        .enable    (extIrqEnable[1]),
        .ioClkRun  (ioClkRun),
        .flagClear (extIrqAck[1]),
        .edgeFlag  (edgeB),
        .lowLevel  (lowB)
    );

    // a level still present once the i/o clock runs becomes the request
    assign extIrqReqA = edgeA || (lowA && ioClkRun);               // see RQ8
    assign extIrqReqB = edgeB || (lowB && ioClkRun);               // see RQ12

    a_group2_toggle: assert property (@(posedge clock) // see RQ2
        disable iff (!rstn)
        changeEnable[2] && |(chgToggle[23:16] & changeMaskGroup2)
        |=> changeReqGroup2)
        else $error("group2 toggle did not request");

    a_group1_toggle: assert property (@(posedge clock) // see RQ3
        disable iff (!rstn)
        changeEnable[1] && |(chgToggle[14:8] & changeMaskGroup1[6:0])
        |=> changeReqGroup1)
        else $error("group1 toggle did not request");

    a_group0_toggle: assert property (@(posedge clock) // see RQ4
        disable iff (!rstn)
        changeEnable[0] && |(chgToggle[7:0] & changeMaskGroup0)
        |=> changeReqGroup0)
        else $error("group0 toggle did not request");

    a_mask_ignored: assert property (@(posedge clock) // see RQ5
        disable iff (!rstn)
        $rose(changeReqGroup0)
        |-> $past(|(chgToggle[7:0] & changeMaskGroup0)))
        else $error("masked pin raised group0");

    a_driven_pin: assert property (@(posedge clock) // see RQ1
        disable iff (!rstn)
        changeEnable[0] && changePinsOe[0] && changeMaskGroup0[0]
        && $changed(changePinsOut[0]) && $stable(changePinsOe[0])
        |=> ##1 changeReqGroup0)
        else $error("driven pin toggle did not request");

    a_ioclk_stopped: assert property (@(posedge clock) // see RQ10
        disable iff (!rstn)
        (state_q == EPI_ST_SLEEP && !sleepIdleMode)
        || state_q == EPI_ST_STARTUP |-> !ioClockRun)
        else $error("i/o clock runs in deep sleep");

    a_level_hold: assert property (@(posedge clock) // see RQ8
        disable iff (!rstn)
        state_q == EPI_ST_AWAKE && extIrqEnable[0]
        && extIrqSenseCtrl[1:0] == EPI_SENSE_LOW && !levelA
        |-> extIrqReqA)
        else $error("held low level not requested");

    a_startup_noreq: assert property (@(posedge clock) // see RQ12
        disable iff (!rstn)
        state_q == EPI_ST_STARTUP && !edgeA |-> !extIrqReqA)
        else $error("level request during start-up");

    a_level_wake: assert property (@(posedge clock) // see RQ11
        disable iff (!rstn)
        state_q == EPI_ST_SLEEP && lowA |=> wakeUp && state_q != EPI_ST_SLEEP)
        else $error("low level did not wake");

    a_startup_len: assert property (@(posedge clock) // see RQ13
        disable iff (!rstn)
        state_q == EPI_ST_SLEEP && state_d == EPI_ST_STARTUP
        |=> cnt_q == $past(startLoad) || $past(startLoad) == EPI_CNT_ZERO)
        else $error("start-up count not taken from fuses");

    a_startup_end: assert property (@(posedge clock) // see RQ13
        disable iff (!rstn)
        state_q == EPI_ST_STARTUP && cnt_q == EPI_CNT_ONE
        |=> state_q == EPI_ST_AWAKE)
        else $error("start-up did not end");

endmodule

// ==== epi_pin_source.sv ====
`timescale 1ns/1ps
module epi_pin_source (
    input  wire logic        clock,
    output logic [1:0]       dedPins,
    output logic [23:0]      chgPins
);
    // dedicated lines idle high on their pull-ups
    initial begin
        dedPins = 2'h3;
        chgPins = 24'h000000;
    end
    task automatic setLvl(input int w, input logic lvl);
        dedPins[w] = lvl;
    endtask
    task automatic toggle(input int idx);
        chgPins[idx] = ~chgPins[idx];
    endtask
    // a wake level kept for a chosen number of cycles, then let go
    task automatic holdLow(input int w, input int cyc);
        dedPins[w] = 1'b0;
        repeat (cyc) @(posedge clock);
        #1;
        dedPins[w] = 1'b1;
    endtask
endmodule

// ==== test_external_pin_interrupts.sv ====
`timescale 1ns/1ps
module test_external_pin_interrupts
    import epi_pkg::*;
;
    logic        clock, rstn, sleepEnter, idleMode, ioRun, wake;
    logic [1:0]  dPins, dOut, dOe, dEn, dAck, dReq, sutFuses;
    logic [3:0]  sense, ckFuses;
    logic [2:0]  chgEn, chgAck, req;
    logic [23:0] pins, pOut, pOe;
    logic [7:0]  mask [3];
    logic [1:0]  codes [4];
    int          corner [6];
    int          error_cnt;
    int          checked;

    epi_pin_source src_u (.clock(clock), .dedPins(dPins), .chgPins(pins));
    epi_ext_interrupts dut_u (
        .clock(clock), .rstn(rstn), .extIrqPinA(dPins[0]),
        .extIrqPinAOut(dOut[0]), .extIrqPinAOe(dOe[0]),
        .extIrqPinB(dPins[1]), .extIrqPinBOut(dOut[1]),
        .extIrqPinBOe(dOe[1]), .extIrqSenseCtrl(sense),
        .extIrqEnable(dEn), .extIrqAck(dAck), .changePins(pins),
        .changePinsOut(pOut), .changePinsOe(pOe),
        .changeMaskGroup0(mask[0]), .changeMaskGroup1(mask[1]),
        .changeMaskGroup2(mask[2]), .changeEnable(chgEn),
        .changeAck(chgAck), .sleepEnter(sleepEnter),
        .sleepIdleMode(idleMode), .startupTimeFuses(sutFuses),
        .clockSelectFuses(ckFuses), .extIrqReqA(dReq[0]),
        .extIrqReqB(dReq[1]), .changeReqGroup0(req[0]),
        .changeReqGroup1(req[1]), .changeReqGroup2(req[2]),
        .ioClockRun(ioRun), .wakeUp(wake));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic int startN(input logic [1:0] s, input logic [3:0] c);
        int n;
        n = (int'(EPI_STARTUP_UNIT_CYC) << s)
          + int'(EPI_STARTUP_CLOCK_SELECT_FUSES_CYC) * c;
        return (n < 1) ? 1 : n;
    endfunction

    task automatic close_out();
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %b want %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string m);
        checked++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %0d want %0d", $time, m, got, exp);
        end
    endtask

    task automatic ack_all();
        step(4);
        {dAck, chgAck} = 5'h1F;
        step();
        {dAck, chgAck} = 5'h00;
        step();
    endtask

    task automatic go_sleep(input logic idle);
        ack_all();
        idleMode = idle;
        sleepEnter = 1'b1;
        step();
        sleepEnter = 1'b0;
        step(2);
    endtask

    // bounded wait for the wake pulse, then cycles until the clock runs
    task automatic wake_count(output int cnt);
        int i;
        cnt = 0;
        for (i = 0; i < 60 && wake !== 1'b1; i++) step();
        while (ioRun !== 1'b1 && cnt < 2000) begin
            step();
            cnt++;
        end
        if (i == 60 || cnt == 2000) begin
            error_cnt++;
            $display("[FAIL] %0t wake-up timed out", $time);
            close_out();
        end
    endtask

    task automatic pin_change(input int idx, input logic on, input logic drv);
        int g;
        int k;
        logic hit;
        g = idx / 8;
        mask[g][idx % 8] = on;
        pOut[idx] = pins[idx];
        pOe[idx] = drv;
        ack_all();
        if (drv) pOut[idx] = ~pins[idx];
        else src_u.toggle(idx);
        step(4);
        for (k = 0; k < 3; k++) begin
            hit = k == g && on && chgEn[g] && !(g == 1 && idx % 8 == 7);
            chk_bit(req[k], hit, "change");
        end
        pOut[idx] = pins[idx];
        step(2);
        pOe[idx] = 1'b0;
        step();
    endtask

    task automatic set_ded(input int w, input logic drv, input logic lvl);
        if (drv) dOut[w] = lvl;
        else src_u.setLvl(w, lvl);
    endtask

    task automatic ded(input int w, input logic [1:0] code, input logic drv);
        logic fallExp;
        sense[2*w +: 2] = code;
        dEn[w] = 1'b1;
        dOe[w] = drv;
        ack_all();
        set_ded(w, drv, 1'b0);
        step(4);
        fallExp = code == EPI_SENSE_LOW || code == EPI_SENSE_FALL;
        chk_bit(dReq[w], fallExp, "fall");
        ack_all();
        chk_bit(dReq[w], 1'(code == EPI_SENSE_LOW), "held low");
        set_ded(w, drv, 1'b1);
        step(4);
        chk_bit(dReq[w], 1'(code == EPI_SENSE_RISE), "rise");
        dOe[w] = 1'b0;
        dEn[w] = 1'b0;
        step();
    endtask

    task automatic deep_wake(input int hold);
        int n;
        int cnt;
        {sutFuses, ckFuses} = 6'($urandom);
        n = startN(sutFuses, ckFuses);
        sense[1:0] = EPI_SENSE_LOW;
        dEn = 2'h1;
        go_sleep(1'b0);
        chk_bit(ioRun, 1'b0, "deep sleep clock");
        fork
            src_u.holdLow(0, hold);
        join_none
        wake_count(cnt);
        chk_cnt(cnt, n, "start-up length");
        chk_bit(wake, 1'b0, "wake pulse");
        chk_bit(dReq[0], 1'(hold > n + 8), "level wake");
        step(hold);
        chk_bit(dReq[0], 1'b0, "level gone");
    endtask

    initial begin
        int i;
        int cnt;
        error_cnt = 0;
        checked = 0;
        codes = '{EPI_SENSE_LOW, EPI_SENSE_FALL, EPI_SENSE_RISE, 2'h1};
        corner = '{0, 7, 8, 14, 15, 23};
        rstn = 1'b0;
        {sleepEnter, idleMode} = 2'h0;
        {dOut, dOe, dEn, dAck} = 8'hC0;
        sense = 4'hF;
        {sutFuses, ckFuses} = 6'h00;
        {chgEn, chgAck} = 6'h38;
        {pOut, pOe} = 48'h0;
        mask = '{8'h00, 8'h00, 8'h00};
        void'($urandom(35));
        repeat (6) @(posedge clock);
        #1;
        rstn = 1'b1;
        step(4);
        for (i = 0; i < 6; i++) begin
            pin_change(corner[i], 1'b1, 1'(i % 2));
        end
        repeat (40) begin
            chgEn = 3'($urandom);
            pin_change($urandom % 24, 1'($urandom), 1'($urandom));
        end
        chgEn = 3'h7;
        for (i = 0; i < 16; i++) begin
            ded(i % 2, codes[(i / 2) % 4], 1'(i / 8));
        end
        sense[1:0] = EPI_SENSE_FALL;
        dEn = 2'h1;
        go_sleep(1'b1);
        chk_bit(ioRun, 1'b1, "idle clock");
        src_u.setLvl(0, 1'b0);
        wake_count(cnt);
        chk_bit(dReq[0], 1'b1, "idle edge");
        src_u.setLvl(0, 1'b1);
        go_sleep(1'b0);
        src_u.holdLow(0, 3);
        step(3);
        chk_bit(ioRun, 1'b0, "edge in deep sleep");
        mask[0][0] = 1'b1;
        src_u.toggle(0);
        wake_count(cnt);
        chk_bit(req[0], 1'b1, "change wake");
        chk_bit(dReq[0], 1'b0, "edge lost");
        deep_wake(4);
        deep_wake(1200);
        close_out();
    end
endmodule
